// file: core/pjd_angle_track.sv
// Per channel angle history and wrapped angle step over the last window.
`timescale 1ns/1ps
module pjd_angle_track #(
    parameter int unsigned DEPTH = pjd_pkg::HIST_DEPTH
) (
    input  wire logic                                             sys_clk,
    input  wire logic                                             resetn,
    input  wire logic                                             phasor_valid,
    input  wire logic [pjd_pkg::NUM_CH-1:0][pjd_pkg::ANGLE_W-1:0] phase_angle,
    pjd_step_if.producer                                          res
);
    // The history shift needs at least two entries and the fill counter is three bits wide.
    if (DEPTH < 2 || DEPTH > 7) begin : g_chk
        $error("DEPTH must be 2 to 7");
    end

    typedef struct packed {
        logic [pjd_pkg::NUM_CH-1:0][DEPTH-1:0][pjd_pkg::ANGLE_W-1:0] hist;
        logic [2:0]                                                  fill;
        logic [pjd_pkg::NUM_CH-1:0][pjd_pkg::STEP_W-1:0]             step;
        logic [pjd_pkg::NUM_CH-1:0][pjd_pkg::STEP_W-2:0]             step_abs;
    } pjd_track_type;

    pjd_track_type st_r;
    pjd_track_type st_nxt;
    logic [pjd_pkg::NUM_CH-1:0][pjd_pkg::STEP_W-1:0] wrap;

    // ==========================================================================
    // Wrapped difference between the newest angle and the one a window earlier
    // ==========================================================================
    for (genvar c = 0; c < pjd_pkg::NUM_CH; c++) begin : g_ch
        logic signed [pjd_pkg::STEP_W-1:0] raw;
        // Differences beyond half a turn are folded back so a wrap at 180 degrees reads as a small step.
        assign raw = pjd_pkg::STEP_W'($signed(phase_angle[c])) - pjd_pkg::STEP_W'($signed(st_r.hist[c][DEPTH-1]));
        assign wrap[c] = (raw > pjd_pkg::HALF_TURN)  ? raw - pjd_pkg::FULL_TURN :
                         (raw < -pjd_pkg::HALF_TURN) ? raw + pjd_pkg::FULL_TURN : raw;
    end

    // Each fresh phasor set shifts the history and produces one new step per channel.
    always_comb begin
        st_nxt = st_r;
        if (phasor_valid) begin
            for (int c = 0; c < pjd_pkg::NUM_CH; c++) begin
                st_nxt.hist[c]     = {st_r.hist[c][DEPTH-2:0], phase_angle[c]};
                st_nxt.step[c]     = wrap[c];
                // A wrapped step never exceeds half a turn, so its magnitude fits one bit narrower.
                st_nxt.step_abs[c] = wrap[c][pjd_pkg::STEP_W-1] ? (pjd_pkg::STEP_W-1)'(-wrap[c])
                                                                : (pjd_pkg::STEP_W-1)'(wrap[c]);
            end
            if (st_r.fill != 3'(DEPTH)) begin
                st_nxt.fill = st_r.fill + 3'h1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign res.step     = st_r.step;
    assign res.step_abs = st_r.step_abs;
    assign res.ready    = (st_r.fill == 3'(DEPTH));

    property p_ready_needs_window;
        @(posedge sys_clk) disable iff (!resetn) $rose(res.ready) |-> $past(phasor_valid);
    endproperty
    a_ready_needs_window: assert property (p_ready_needs_window) else $error("ready rose without update");
endmodule : pjd_angle_track

// file: core/pjd_detector.sv
// Phase angle jump detector top: pick-up, blocking, trip pulse and status.
`timescale 1ns/1ps
module pjd_detector #(
    parameter int unsigned TRIP_PULSE_CYCLES = pjd_pkg::TRIP_PULSE_CYC
) (
    input  wire logic                                                   sys_clk,
    input  wire logic                                                   resetn,
    input  wire logic                                                   program_tick,
    input  wire logic                                                   phasor_valid,
    input  wire logic [pjd_pkg::NUM_CH-1:0][pjd_pkg::ANGLE_W-1:0]       phase_angle,
    input  wire logic [pjd_pkg::NUM_CH-1:0][pjd_pkg::MAG_W-1:0]         magnitude,
    input  wire logic                                                   line_mode_pe,
    input  wire logic                                                   block_in,
    input  wire logic [2:0]                                             active_group,
    input  wire logic [pjd_pkg::NUM_GROUPS-1:0][pjd_pkg::SET_W-1:0]     trip_step_set,
    input  wire logic [pjd_pkg::NUM_GROUPS-1:0][pjd_pkg::SET_W-1:0]     alarm_step_set,
    input  wire logic [pjd_pkg::NUM_GROUPS-1:0][pjd_pkg::UV_W-1:0]      uv_limit_set,
    input  wire logic [pjd_pkg::NUM_GROUPS-1:0][3:0]                    channel_select,
    input  wire logic                                                   stage_forcing_enable,
    input  wire logic [1:0]                                             force_status,
    input  wire logic                                                   stage_select,
    output      logic                                                   trip_out,
    output      logic                                                   alarm_out,
    output      logic                                                   blocked_out,
    output      logic [1:0]                                             status_out,
    output      logic                                                   selection_ok,
    output      logic [pjd_pkg::NUM_CH-1:0][pjd_pkg::STEP_W-1:0]        angle_step,
    output      logic [pjd_pkg::NUM_CH-1:0][pjd_pkg::RATIO_W-1:0]       step_ratio
);
    localparam int unsigned CNT_W = $clog2(TRIP_PULSE_CYCLES + 1);

    if (TRIP_PULSE_CYCLES < 2) begin : g_chk
        $error("TRIP_PULSE_CYCLES must be at least 2");
    end

    typedef struct packed {
        pjd_pkg::pjd_state_type                           fsm;
        logic [CNT_W-1:0]                                 cnt;
        logic                                             trip;
        logic                                             alarm;
        logic                                             blocked;
        logic [1:0]                                       status;
        logic                                             sel_ok;
        logic [pjd_pkg::NUM_CH-1:0][pjd_pkg::STEP_W-1:0]  step;
        logic [pjd_pkg::NUM_CH-1:0][pjd_pkg::RATIO_W-1:0] ratio;
    } pjd_main_type;

    pjd_main_type st_r;
    pjd_main_type st_nxt;

    pjd_step_if step_bus ();

    // ==========================================================================
    // Angle tracking
    // ==========================================================================
    // The phasor angles already come from the front end's 64 point sampling, refreshed every 5 ms.
    pjd_angle_track #(
        .DEPTH (pjd_pkg::HIST_DEPTH)
    ) u_track (
        .sys_clk      (sys_clk),
        .resetn       (resetn),
        .phasor_valid (phasor_valid),
        .phase_angle  (phase_angle),
        .res          (step_bus.producer)
    );

    // ==========================================================================
    // Active settings
    // ==========================================================================
    logic [pjd_pkg::SET_W-1:0] trip_set;
    logic [pjd_pkg::SET_W-1:0] alarm_set;
    logic [pjd_pkg::UV_W-1:0]  uv_set;
    logic [3:0]                sel;

    // Group-indexed settings switch over live; out of range step and undervoltage values are clamped to the legal span.
    always_comb begin
        trip_set  = trip_step_set[active_group];
        alarm_set = alarm_step_set[active_group];
        uv_set    = uv_limit_set[active_group];
        sel       = channel_select[active_group];
        if (trip_set < pjd_pkg::STEP_SET_MIN) trip_set = pjd_pkg::STEP_SET_MIN;
        if (trip_set > pjd_pkg::STEP_SET_MAX) trip_set = pjd_pkg::STEP_SET_MAX;
        if (alarm_set < pjd_pkg::STEP_SET_MIN) alarm_set = pjd_pkg::STEP_SET_MIN;
        if (alarm_set > pjd_pkg::STEP_SET_MAX) alarm_set = pjd_pkg::STEP_SET_MAX;
        if (uv_set < pjd_pkg::UV_MIN) uv_set = pjd_pkg::UV_MIN;
        if (uv_set > pjd_pkg::UV_MAX) uv_set = pjd_pkg::UV_MAX;
    end

    // ==========================================================================
    // Channel selection
    // ==========================================================================
    logic [pjd_pkg::NUM_CH-1:0] mask;
    logic                       need_all;
    logic                       mode_ok;

    // Line channels carry either pair or line-to-earth voltages; the choice must match the wiring.
    always_comb begin
        mask     = 4'h0;
        need_all = 1'b0;
        mode_ok  = 1'b1;
        case (sel)
            pjd_pkg::SEL_ALL_PP: begin mask = 4'h7; need_all = 1'b1; mode_ok = !line_mode_pe; end
            pjd_pkg::SEL_ANY_PP: begin mask = 4'h7; mode_ok = !line_mode_pe; end
            pjd_pkg::SEL_PAIR1:  begin mask = 4'h1; mode_ok = !line_mode_pe; end
            pjd_pkg::SEL_PAIR2:  begin mask = 4'h2; mode_ok = !line_mode_pe; end
            pjd_pkg::SEL_PAIR3:  begin mask = 4'h4; mode_ok = !line_mode_pe; end
            pjd_pkg::SEL_ALL_PE: begin mask = 4'h7; need_all = 1'b1; mode_ok = line_mode_pe; end
            pjd_pkg::SEL_ANY_PE: begin mask = 4'h7; mode_ok = line_mode_pe; end
            pjd_pkg::SEL_LINE1:  begin mask = 4'h1; mode_ok = line_mode_pe; end
            pjd_pkg::SEL_LINE2:  begin mask = 4'h2; mode_ok = line_mode_pe; end
            pjd_pkg::SEL_LINE3:  begin mask = 4'h4; mode_ok = line_mode_pe; end
            pjd_pkg::SEL_AUX:    begin mask = 4'h8; end
            default:             begin mask = 4'h0; mode_ok = 1'b0; end
        endcase
    end

    // ==========================================================================
    // Per channel comparison and ratio
    // ==========================================================================
    logic [pjd_pkg::NUM_CH-1:0]                       trip_exc;
    logic [pjd_pkg::NUM_CH-1:0]                       alarm_exc;
    logic [pjd_pkg::NUM_CH-1:0]                       under_v;
    logic [pjd_pkg::NUM_CH-1:0][pjd_pkg::RATIO_W-1:0] ratio;

    for (genvar c = 0; c < pjd_pkg::NUM_CH; c++) begin : g_cmp
        logic [23:0] quot;
        // Magnitude of the step is compared so leading and lagging jumps behave alike.
        assign trip_exc[c]  = step_bus.step_abs[c] >= 16'(trip_set);
        assign alarm_exc[c] = step_bus.step_abs[c] >= 16'(alarm_set);
        assign under_v[c]   = magnitude[c] < 16'(uv_set);
        // The divider runs every clock but only its tick-time value is kept, so it needs no pipeline.
        assign quot     = (24'(step_bus.step_abs[c]) * 24'(pjd_pkg::RATIO_SCALE)) / 24'(trip_set);
        assign ratio[c] = (quot > 24'(pjd_pkg::RATIO_SAT)) ? pjd_pkg::RATIO_SAT : quot[15:0];
    end

    logic pick_trip;
    logic pick_alarm;
    logic uv_block;

    // An all selection needs every chosen channel; any selection needs just one.
    assign pick_trip  = step_bus.ready && mode_ok && (need_all ? &(trip_exc | ~mask) : |(trip_exc & mask));
    assign pick_alarm = step_bus.ready && mode_ok && (need_all ? &(alarm_exc | ~mask) : |(alarm_exc & mask));
    assign uv_block   = |(under_v & mask);

    // ==========================================================================
    // Decision and trip pulse
    // ==========================================================================
    // Block is sampled only on the program tick, so it must settle before the tick that decides.
    always_comb begin
        st_nxt = st_r;
        if (program_tick) begin
            st_nxt.sel_ok  = mode_ok;
            st_nxt.step    = step_bus.step;
            st_nxt.ratio   = ratio;
            // An alarm pick-up only counts while the alarm stage is chosen.
            st_nxt.blocked = (pick_trip || (pick_alarm && stage_select == pjd_pkg::STAGE_TRIP_ALARM))
                             && (block_in || uv_block);
            st_nxt.alarm   = pick_alarm && !block_in && !uv_block
                             && (stage_select == pjd_pkg::STAGE_TRIP_ALARM);
        end
        unique case (st_r.fsm)
            pjd_pkg::FSM_WATCH: begin
                // The one stage trips on the tick itself with no definite delay.
                if (program_tick && pick_trip && !block_in && !uv_block) begin
                    st_nxt.fsm  = pjd_pkg::FSM_PULSE;
                    st_nxt.trip = 1'b1;
                    st_nxt.cnt  = '0;
                end
            end
            pjd_pkg::FSM_PULSE: begin
                // The pulse ends on its own; new pick-ups during it do not retrigger.
                if (st_r.cnt == CNT_W'(TRIP_PULSE_CYCLES - 1)) begin
                    st_nxt.fsm  = pjd_pkg::FSM_WATCH;
                    st_nxt.trip = 1'b0;
                end else begin
                    st_nxt.cnt = st_r.cnt + 1'b1;
                end
            end
        endcase
        // Forcing is a plain input, never group indexed, and overrides the reported status.
        if (stage_forcing_enable) begin
            st_nxt.status = force_status;
        end else if (st_nxt.trip) begin
            st_nxt.status = pjd_pkg::ST_TRIP;
        end else if (st_nxt.blocked) begin
            st_nxt.status = pjd_pkg::ST_BLOCKED;
        end else if (st_nxt.alarm) begin
            st_nxt.status = pjd_pkg::ST_ALARM;
        end else begin
            st_nxt.status = pjd_pkg::ST_NORMAL;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign trip_out     = st_r.trip;
    assign alarm_out    = st_r.alarm;
    assign blocked_out  = st_r.blocked;
    assign status_out   = st_r.status;
    assign selection_ok = st_r.sel_ok;
    assign angle_step   = st_r.step;
    assign step_ratio   = st_r.ratio;

    // ==========================================================================
    // Assertions
    // ==========================================================================
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    property p_trip_instant;
        program_tick && pick_trip && !block_in && !uv_block && !trip_out |=> trip_out && st_r.cnt == '0;
    endproperty
    a_trip_instant: assert property (p_trip_instant) else $error("trip not raised at pick-up");

    property p_trip_holds;
        trip_out && st_r.cnt < CNT_W'(TRIP_PULSE_CYCLES - 1) |=> trip_out;
    endproperty
    a_trip_holds: assert property (p_trip_holds) else $error("trip pulse ended early");

    property p_trip_ends;
        trip_out && st_r.cnt == CNT_W'(TRIP_PULSE_CYCLES - 1) |=> !trip_out;
    endproperty
    a_trip_ends: assert property (p_trip_ends) else $error("trip pulse not ended");

    property p_blocked_no_trip;
        program_tick && block_in && !trip_out |=> !$rose(trip_out);
    endproperty
    a_blocked_no_trip: assert property (p_blocked_no_trip) else $error("trip while blocked");

    property p_uv_block;
        program_tick && uv_block && !trip_out |=> !trip_out && !alarm_out;
    endproperty
    a_uv_block: assert property (p_uv_block) else $error("acted under undervoltage");

    property p_alarm_stage;
        stage_select == pjd_pkg::STAGE_TRIP && $stable(stage_select) |=> !alarm_out || $past(program_tick, 1) == 1'b0;
    endproperty
    a_alarm_stage: assert property (p_alarm_stage) else $error("alarm in trip only stage");

    property p_force;
        stage_forcing_enable |=> status_out == $past(force_status);
    endproperty
    a_force: assert property (p_force) else $error("forced status not shown");

    property p_ratio_update;
        program_tick |=> step_ratio == $past(ratio);
    endproperty
    a_ratio_update: assert property (p_ratio_update) else $error("ratio not refreshed");

    property p_pick_any;
        program_tick && !need_all && step_bus.ready && mode_ok && |(trip_exc & mask) && !block_in && !uv_block
        && !trip_out |=> trip_out;
    endproperty
    a_pick_any: assert property (p_pick_any) else $error("any selection missed pick-up");

    c_trip:    cover property (!trip_out ##1 trip_out);
    c_blocked: cover property ($rose(blocked_out));
    c_alarm:   cover property ($rose(alarm_out));
    c_force:   cover property (stage_forcing_enable && force_status == pjd_pkg::ST_TRIP);
endmodule : pjd_detector

// file: core/pjd_pkg.sv
// Shared constants and types of the phase angle jump detector.
package pjd_pkg;

    // ==========================================================================
    // Timing
    // ==========================================================================
    localparam int unsigned CLK_PERIOD_NS     = 4;
    localparam int unsigned SAMPLES_PER_CYCLE = 64;  // Front end sampling density per channel.
    localparam int unsigned PHASOR_PERIOD_MS  = 5;
    localparam int unsigned ANGLE_WINDOW_MS   = 20;
    localparam int unsigned TRIP_PULSE_MS     = 20;
    localparam int unsigned TRIP_PULSE_CYC    = TRIP_PULSE_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned HIST_DEPTH        = ANGLE_WINDOW_MS / PHASOR_PERIOD_MS;

    // ==========================================================================
    // Widths and scaling (angles in 0.01 degree, voltages in 0.01 percent)
    // ==========================================================================
    localparam int unsigned NUM_CH     = 4;
    localparam int unsigned NUM_GROUPS = 8;
    localparam int unsigned ANGLE_W    = 16;
    localparam int unsigned STEP_W     = 17;
    localparam int unsigned MAG_W      = 16;
    localparam int unsigned SET_W      = 12;
    localparam int unsigned UV_W       = 14;
    localparam int unsigned RATIO_W    = 16;

    localparam logic signed [STEP_W-1:0] FULL_TURN = 17'sh08ca0;
    localparam logic signed [STEP_W-1:0] HALF_TURN = 17'sh04650;

    localparam logic [SET_W-1:0]   STEP_SET_MIN = 12'h005;
    localparam logic [SET_W-1:0]   STEP_SET_MAX = 12'hbb8;
    localparam logic [SET_W-1:0]   STEP_SET_DEF = 12'h1f4;
    localparam logic [UV_W-1:0]    UV_MIN       = 14'h0001;
    localparam logic [UV_W-1:0]    UV_MAX       = 14'h2710;
    localparam logic [UV_W-1:0]    UV_DEF       = 14'h251c;
    localparam logic [7:0]         RATIO_SCALE  = 8'h64;
    localparam logic [RATIO_W-1:0] RATIO_SAT    = 16'hffff;

    // ==========================================================================
    // Enumerations
    // ==========================================================================
    typedef enum logic [1:0] {
        ST_NORMAL  = 2'h0,
        ST_BLOCKED = 2'h1,
        ST_TRIP    = 2'h2,
        ST_ALARM   = 2'h3
    } pjd_status_type;

    typedef enum logic {
        STAGE_TRIP       = 1'b0,
        STAGE_TRIP_ALARM = 1'b1
    } pjd_stage_type;

    typedef enum logic [3:0] {
        SEL_ALL_PP = 4'h0, SEL_ANY_PP = 4'h1, SEL_PAIR1 = 4'h2, SEL_PAIR2 = 4'h3,
        SEL_PAIR3  = 4'h4, SEL_ALL_PE = 4'h5, SEL_ANY_PE = 4'h6, SEL_LINE1 = 4'h7,
        SEL_LINE2  = 4'h8, SEL_LINE3  = 4'h9, SEL_AUX    = 4'ha
    } pjd_chsel_type;

    typedef enum logic {
        FSM_WATCH = 1'b0,
        FSM_PULSE = 1'b1
    } pjd_state_type;

endpackage : pjd_pkg

// file: core/pjd_step_if.sv
// Angle step results passed from the angle tracker to the decision logic.
`timescale 1ns/1ps
interface pjd_step_if;
    logic [pjd_pkg::NUM_CH-1:0][pjd_pkg::STEP_W-1:0] step;
    logic [pjd_pkg::NUM_CH-1:0][pjd_pkg::STEP_W-2:0] step_abs;
    logic                                            ready;

    modport producer (output step, output step_abs, output ready);
    modport consumer (input step, input step_abs, input ready);
endinterface : pjd_step_if

// file: verification/pjd_detector_bench.sv
// Self-checking bench of the phase angle jump detector.
`timescale 1ns/1ps
module pjd_detector_bench;
    // ==========================================
    // Stimulus and observed signals
    // ==========================================
    localparam int unsigned PULSE = 20;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic program_tick = 1'b0;
    logic line_mode_pe = 1'b0;
    logic block_in = 1'b0;
    logic [2:0] active_group = 3'h0;
    logic [7:0][11:0] trip_step_set = {8{pjd_pkg::STEP_SET_DEF}};
    logic [7:0][11:0] alarm_step_set = {8{pjd_pkg::STEP_SET_DEF}};
    logic [7:0][13:0] uv_limit_set = {8{pjd_pkg::UV_DEF}};
    logic [7:0][3:0] channel_select = {8{4'h1}};
    logic stage_forcing_enable = 1'b0;
    logic [1:0] force_status = 2'h0;
    logic stage_select = 1'b0;
    logic phasor_valid, trip_out, alarm_out, blocked_out, selection_ok;
    logic [1:0] status_out;
    logic [3:0][15:0] phase_angle, magnitude, step_ratio;
    logic [3:0][16:0] angle_step;
    int n_mismatch = 0;
    int n_compared = 0;

    // Free running 250 MHz clock.
    always #2 sys_clk = ~sys_clk;

    pjd_front_end i_pjd_front_end (.sys_clk(sys_clk), .phasor_valid(phasor_valid),
        .phase_angle(phase_angle), .magnitude(magnitude));

    // A short pulse length keeps each trip scenario to a few dozen cycles.
    pjd_detector #(.TRIP_PULSE_CYCLES(PULSE)) i_pjd_detector (.sys_clk(sys_clk), .resetn(resetn),
        .program_tick(program_tick), .phasor_valid(phasor_valid), .phase_angle(phase_angle),
        .magnitude(magnitude), .line_mode_pe(line_mode_pe), .block_in(block_in),
        .active_group(active_group), .trip_step_set(trip_step_set), .alarm_step_set(alarm_step_set),
        .uv_limit_set(uv_limit_set), .channel_select(channel_select),
        .stage_forcing_enable(stage_forcing_enable), .force_status(force_status),
        .stage_select(stage_select), .trip_out(trip_out), .alarm_out(alarm_out),
        .blocked_out(blocked_out), .status_out(status_out), .selection_ok(selection_ok),
        .angle_step(angle_step), .step_ratio(step_ratio));

    // ==========================================
    // Shared tasks
    // ==========================================
    task automatic complete_run;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : complete_run

    task automatic chk(input logic [16:0] got, input logic [16:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask : chk

    // Flush the history with zeros so the jump is measured against a known angle.
    task automatic jump(input logic [3:0] mask, input logic [15:0] d);
        logic [3:0][15:0] a;
        for (int i = 0; i < 4; i++) a[i] = mask[i] ? d : 16'h0000;
        repeat (4) i_pjd_front_end.send('0);
        i_pjd_front_end.send(a);
        @(posedge sys_clk) program_tick <= 1'b1;
        @(posedge sys_clk) program_tick <= 1'b0;
        #1;
    endtask : jump

    // Judge flags and status just after the deciding edge, then time the whole trip pulse.
    task automatic expect_out(input logic t, input logic al, input logic bl, input string what);
        int n = 0;
        logic [1:0] st = t ? pjd_pkg::ST_TRIP : bl ? pjd_pkg::ST_BLOCKED : al ? pjd_pkg::ST_ALARM : pjd_pkg::ST_NORMAL;
        chk(17'({status_out, trip_out, alarm_out, blocked_out}), 17'({st, t, al, bl}), what);
        while (trip_out === 1'b1 && n < 40) begin
            n++;
            @(posedge sys_clk) #1;
        end
        if (n == 40) begin
            n_mismatch++;
            complete_run();
        end
        if (t) chk(17'(n), 17'(PULSE), what);
        repeat (4) @(posedge sys_clk);
        $display("test done: %s", what);
    endtask : expect_out

    // ==========================================
    // Scenarios
    // ==========================================
    task automatic t_trip;
        jump(4'h1, 16'd500);
        chk(angle_step[0], 17'd500, "step value");
        chk(17'(step_ratio[0]), 17'd100, "ratio value");
        expect_out(1'b1, 1'b0, 1'b0, "trip at threshold");
        jump(4'h1, 16'd499);
        expect_out(1'b0, 1'b0, 1'b0, "just below threshold");
        jump(4'h1, -16'sd600);
        chk(angle_step[0], 17'h1fda8, "lagging step value");
        expect_out(1'b1, 1'b0, 1'b0, "lagging jump");
    endtask : t_trip

    task automatic t_block;
        @(posedge sys_clk) block_in <= 1'b1;
        jump(4'h1, 16'd600);
        expect_out(1'b0, 1'b0, 1'b1, "external block");
        @(posedge sys_clk) block_in <= 1'b0;
        i_pjd_front_end.set_level(16'h251b);
        jump(4'h1, 16'd600);
        expect_out(1'b0, 1'b0, 1'b1, "undervoltage");
        i_pjd_front_end.set_level(16'h2710);
    endtask : t_block

    task automatic t_select;
        @(posedge sys_clk) channel_select[0] <= 4'h0;
        jump(4'h3, 16'd600);
        expect_out(1'b0, 1'b0, 1'b0, "all pairs partial");
        jump(4'h7, 16'd600);
        expect_out(1'b1, 1'b0, 1'b0, "all pairs full");
        @(posedge sys_clk) channel_select[0] <= 4'ha;
        jump(4'h8, 16'd600);
        expect_out(1'b1, 1'b0, 1'b0, "auxiliary channel");
    endtask : t_select

    // Earth selections must be refused on pair wiring and accepted on earth wiring.
    task automatic t_wiring;
        @(posedge sys_clk) channel_select[1] <= 4'h5;
        jump(4'h7, 16'd600);
        chk(17'(selection_ok), 17'h0, "earth selection on pair wiring");
        expect_out(1'b0, 1'b0, 1'b0, "wiring mismatch");
        @(posedge sys_clk) line_mode_pe <= 1'b1;
        jump(4'h7, 16'd600);
        chk(17'(selection_ok), 17'h1, "earth selection on earth wiring");
        expect_out(1'b1, 1'b0, 1'b0, "all earth voltages");
    endtask : t_wiring

    task automatic t_alarm;
        @(posedge sys_clk);
        channel_select[0] <= 4'h1;
        stage_select <= 1'b1;
        trip_step_set[0] <= 12'd1000;
        alarm_step_set[0] <= 12'd300;
        jump(4'h1, 16'd600);
        expect_out(1'b0, 1'b1, 1'b0, "alarm only");
        @(posedge sys_clk) stage_select <= 1'b0;
        jump(4'h1, 16'd600);
        expect_out(1'b0, 1'b0, 1'b0, "alarm stage off");
        @(posedge sys_clk) active_group <= 3'h1;
        jump(4'h1, 16'd600);
        expect_out(1'b1, 1'b0, 1'b0, "group switch");
    endtask : t_alarm

    task automatic t_force;
        @(posedge sys_clk) force_status <= 2'h3;
        repeat (2) @(posedge sys_clk);
        #1 chk(17'(status_out), 17'h0, "forcing disabled");
        @(posedge sys_clk) stage_forcing_enable <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1 chk(17'(status_out), 17'h3, "forced alarm");
        $display("test done: forcing");
    endtask : t_force

    // Reset for twelve cycles, then run every scenario in turn.
    initial begin
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        t_trip();
        t_block();
        t_select();
        t_alarm();
        t_wiring();
        t_force();
        complete_run();
    end
endmodule : pjd_detector_bench

// file: verification/pjd_front_end.sv
// Behavioural phasor front end that feeds the detector.
`timescale 1ns/1ps
module pjd_front_end (
    input  wire logic             sys_clk,
    output      logic             phasor_valid,
    output      logic [3:0][15:0] phase_angle,
    output      logic [3:0][15:0] magnitude
);
    // ==========================================
    // Phasor delivery
    // ==========================================
    // Healthy voltage at start, no strobe pending.
    initial begin
        phasor_valid = 1'b0;
        phase_angle  = '0;
        magnitude    = {4{16'h2710}};
    end

    // All four channels arrive in one strobe; angles go inverted after it so a late read is caught.
    task automatic send(input logic [3:0][15:0] ang);
        @(posedge sys_clk);
        phasor_valid <= 1'b1;
        phase_angle  <= ang;
        @(posedge sys_clk);
        phasor_valid <= 1'b0;
        phase_angle  <= ~ang;
    endtask : send

    // Voltage level of all channels, changed just after an edge like every other input.
    task automatic set_level(input logic [15:0] lvl);
        @(posedge sys_clk);
        magnitude <= {4{lvl}};
    endtask : set_level
endmodule : pjd_front_end
